//--- design/cmcr_top.sv
`timescale 1ns/1ps
`default_nettype none

module cmcr_top (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RESETN,
    // Register command port
    input wire cmcr_pkg::cmcr_wr_req_s WR_REQ,
    input wire cmcr_pkg::cmcr_rd_req_s RD_REQ,
    output var cmcr_pkg::cmcr_rd_rsp_s RD_RSP,
    // Device pins and analog status
    input wire logic SHARED_PIN,
    input wire logic INPUT_ABOVE_LOCKOUT,
    input wire logic FLOOR_MEASURE_DONE,
    // Mode controls
    output var cmcr_pkg::cmcr_ctrl_s CTRL
);
    import cmcr_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cmcr_state_s st_q;
    cmcr_state_s st_d;
    logic wr_hit;
    logic rd_hit;

    // Command decode for this register only
    assign wr_hit = WR_REQ.stb && (WR_REQ.cmd == CMCR_CMD_MODE_CTRL);
    assign rd_hit = RD_REQ.stb && (RD_REQ.cmd == CMCR_CMD_MODE_CTRL);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    // Register update, read answer and mode outputs
    always_comb begin
        logic [15:0] r;
        logic restore;
        // Start from the stored word; later steps win in the order
        // below, so a restore always has the last say over a write.
        // The converter outputs are taken from the same word that is
        // stored, so the register and its effects never disagree.
        r = st_q.mode_ctrl;
        restore = 1'b0;
        st_d = st_q;
        // Floor measurement finished: bit drops, converter resumes
        if (FLOOR_MEASURE_DONE && st_q.mode_ctrl[CMCR_BIT_REMEASURE]) begin
            r[CMCR_BIT_REMEASURE] = 1'b0;
        end
        // Host write; a new request wins over a same-cycle completion
        if (wr_hit) begin
            r = WR_REQ.data;
            if (WR_REQ.data[CMCR_BIT_RESTORE]) begin
                restore = 1'b1;
            end
        end
        // Restore reloads defaults, which also clears the restore bit
        if (restore) begin
            r = CMCR_MODE_CTRL_RST;
        end
        r[CMCR_BIT_RESTORE] = 1'b0;
        st_d.mode_ctrl = r;
        // Read answer, one cycle after the request
        st_d.rsp.ack = rd_hit;
        st_d.rsp.data = rd_hit ? st_q.mode_ctrl : st_q.rsp.data;
        // Mode outputs follow the next register value
        // Pins are sampled here, so each pin-gated mode output lags its pin by
        // one clock; the receiver sees no glitch from a pin change.
        st_d.ctrl.restore_all = restore;
        st_d.ctrl.high_impedance = r[CMCR_BIT_HIZ];
        st_d.ctrl.regulator_on = r[CMCR_BIT_HIZ] && INPUT_ABOVE_LOCKOUT;
        st_d.ctrl.system_from_battery =
            r[CMCR_BIT_HIZ] && INPUT_ABOVE_LOCKOUT;
        st_d.ctrl.floor_measure_req = r[CMCR_BIT_REMEASURE];
        st_d.ctrl.converter_halt = r[CMCR_BIT_REMEASURE];
        st_d.ctrl.reverse_supply_active = r[CMCR_BIT_REVERSE]
            && SHARED_PIN && r[CMCR_BIT_PIN_SELECT];
        st_d.ctrl.assist_active =
            SHARED_PIN && !r[CMCR_BIT_PIN_SELECT];
        st_d.ctrl.conservative_assist_active = r[CMCR_BIT_CONS_ASSIST]
            && SHARED_PIN && !r[CMCR_BIT_PIN_SELECT];
        st_d.ctrl.input_current_optimizer_on = r[CMCR_BIT_ICO];
    end

    // State register
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_q <= CMCR_STATE_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign RD_RSP = st_q.rsp;
    assign CTRL = st_q.ctrl;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_restore_write;
        wr_hit && WR_REQ.data[CMCR_BIT_RESTORE];
    endsequence

    sequence s_remeasure_write;
        wr_hit && WR_REQ.data[CMCR_BIT_REMEASURE];
    endsequence

    a_read_returns_value: assert property (
        rd_hit |=> RD_RSP.ack && RD_RSP.data == $past(st_q.mode_ctrl))
        else $error("read data does not match register");

    a_restore_to_default: assert property (
        s_restore_write |=> st_q.mode_ctrl == CMCR_MODE_CTRL_RST
            && CTRL.restore_all ##1 (!CTRL.restore_all
            || $past(wr_hit && WR_REQ.data[CMCR_BIT_RESTORE])))
        else $error("restore did not reload defaults");

    a_restore_bit_zero: assert property (
        rd_hit |=> !RD_RSP.data[CMCR_BIT_RESTORE])
        else $error("restore bit read back as one");

    a_hiz_follows_write: assert property (
        wr_hit && !WR_REQ.data[CMCR_BIT_RESTORE]
        |=> CTRL.high_impedance == $past(WR_REQ.data[CMCR_BIT_HIZ]))
        else $error("high impedance output wrong after write");

    a_hiz_regulator: assert property (
        CTRL.regulator_on |-> CTRL.high_impedance && CTRL.system_from_battery)
        else $error("regulator on outside high impedance");

    a_halt_on_measure: assert property (
        s_remeasure_write ##0 !WR_REQ.data[CMCR_BIT_RESTORE]
        |=> CTRL.converter_halt && CTRL.floor_measure_req)
        else $error("converter not halted for measurement");

    a_measure_done_clears: assert property (
        FLOOR_MEASURE_DONE && st_q.mode_ctrl[CMCR_BIT_REMEASURE] && !wr_hit
        |=> !st_q.mode_ctrl[CMCR_BIT_REMEASURE] && !CTRL.converter_halt)
        else $error("measurement completion did not restart converter");

    a_reverse_gated: assert property (
        CTRL.reverse_supply_active |-> $past(SHARED_PIN)
            && st_q.mode_ctrl[CMCR_BIT_REVERSE]
            && st_q.mode_ctrl[CMCR_BIT_PIN_SELECT])
        else $error("reverse supply without pin and bit");

    a_pin_assist_select: assert property (
        $past(SHARED_PIN) && !st_q.mode_ctrl[CMCR_BIT_PIN_SELECT]
        |-> CTRL.assist_active && !CTRL.reverse_supply_active)
        else $error("shared pin did not drive assist");

    a_ico_enable: assert property (
        CTRL.input_current_optimizer_on == st_q.mode_ctrl[CMCR_BIT_ICO])
        else $error("optimizer enable mismatch");

    a_cons_assist: assert property (
        CTRL.conservative_assist_active
        |-> CTRL.assist_active && st_q.mode_ctrl[CMCR_BIT_CONS_ASSIST])
        else $error("conservative assist without enable");

    a_pin_reverse_select: assert property (
        $past(SHARED_PIN) && st_q.mode_ctrl[CMCR_BIT_PIN_SELECT]
        |-> !CTRL.assist_active)
        else $error("assist active while pin selects reverse");

    // ------------------------------------------------------------
    // Further checks on the read answer, the stored word and the mode outputs
    // ------------------------------------------------------------
    sequence s_plain_write;
        wr_hit && !WR_REQ.data[CMCR_BIT_RESTORE];
    endsequence

    sequence s_measure_pending;
        st_q.mode_ctrl[CMCR_BIT_REMEASURE] && !FLOOR_MEASURE_DONE;
    endsequence

    // An answer only ever follows a taken read
    a_ack_from_read: assert property (
        RD_RSP.ack |-> $past(rd_hit))
        else $error("read answer without a read");

    // Foreign command codes get no answer
    a_no_foreign_ack: assert property (
        !rd_hit |=> !RD_RSP.ack)
        else $error("answer to a foreign command");

    // Read data holds between answers
    a_data_holds: assert property (
        !rd_hit |=> $stable(RD_RSP.data))
        else $error("read data moved without a read");

    // Without a write or a completion the word stays put
    a_word_stable: assert property (
        !wr_hit && !FLOOR_MEASURE_DONE |=> $stable(st_q.mode_ctrl))
        else $error("register changed without a write");

    // The restore pulse has a restore write behind it
    a_restore_cause: assert property (
        CTRL.restore_all |-> $past(wr_hit && WR_REQ.data[CMCR_BIT_RESTORE]))
        else $error("restore pulse without restore write");

    // After a restore the default modes are back in force
    a_restore_outputs: assert property (
        s_restore_write |=> !CTRL.high_impedance && !CTRL.converter_halt
            && !CTRL.input_current_optimizer_on)
        else $error("restore left a mode output on");

    // The restore bit is never held in the stored word
    a_restore_never_held: assert property (
        !st_q.mode_ctrl[CMCR_BIT_RESTORE])
        else $error("restore bit stored as one");

    // High impedance output mirrors its bit
    a_hiz_matches_bit: assert property (
        CTRL.high_impedance == st_q.mode_ctrl[CMCR_BIT_HIZ])
        else $error("high impedance output differs from bit");

    // Above lockout in high impedance: regulator and battery feed
    a_hiz_lockout_on: assert property (
        CTRL.high_impedance && $past(INPUT_ABOVE_LOCKOUT)
        |-> CTRL.regulator_on && CTRL.system_from_battery)
        else $error("regulator off in high impedance above lockout");

    // Outside high impedance the regulator flag stays low
    a_hiz_off_reg_off: assert property (
        !CTRL.high_impedance |-> !CTRL.regulator_on)
        else $error("regulator flag outside high impedance");

    // Halt and measurement request travel together with the bit
    a_halt_matches_bit: assert property (
        CTRL.converter_halt == st_q.mode_ctrl[CMCR_BIT_REMEASURE]
        && CTRL.floor_measure_req == CTRL.converter_halt)
        else $error("halt output differs from bit");

    // The measurement bit waits for completion
    a_measure_holds: assert property (
        s_measure_pending ##0 !wr_hit
        |=> st_q.mode_ctrl[CMCR_BIT_REMEASURE])
        else $error("measurement bit dropped early");

    // A new request wins over a completion in the same cycle
    a_write_beats_done: assert property (
        s_remeasure_write ##0 FLOOR_MEASURE_DONE
        ##0 !WR_REQ.data[CMCR_BIT_RESTORE]
        |=> st_q.mode_ctrl[CMCR_BIT_REMEASURE])
        else $error("completion beat a new measurement request");

    // Bit, pin and selector all set: reverse supply runs
    a_reverse_enabled: assert property (
        $past(SHARED_PIN) && st_q.mode_ctrl[CMCR_BIT_REVERSE]
        && st_q.mode_ctrl[CMCR_BIT_PIN_SELECT]
        |-> CTRL.reverse_supply_active)
        else $error("reverse supply off with bit and pin set");

    // Optimizer enable follows a plain write
    a_ico_follows_write: assert property (
        s_plain_write
        |=> CTRL.input_current_optimizer_on == $past(WR_REQ.data[CMCR_BIT_ICO]))
        else $error("optimizer enable wrong after write");

    // Conservative assist runs when assist runs and its bit is set
    a_cons_enabled: assert property (
        $past(SHARED_PIN) && !st_q.mode_ctrl[CMCR_BIT_PIN_SELECT]
        && st_q.mode_ctrl[CMCR_BIT_CONS_ASSIST]
        |-> CTRL.conservative_assist_active)
        else $error("conservative assist off with bit set");

    // Assist needs the pin and the assist selection
    a_assist_cause: assert property (
        CTRL.assist_active
        |-> $past(SHARED_PIN) && !st_q.mode_ctrl[CMCR_BIT_PIN_SELECT])
        else $error("assist without pin or selection");

    // A low pin turns assist and reverse supply off
    a_pin_low_off: assert property (
        !$past(SHARED_PIN)
        |-> !CTRL.assist_active && !CTRL.reverse_supply_active)
        else $error("pin-driven mode on with pin low");

endmodule

`default_nettype wire

//--- design/cmcr_pkg.sv
package cmcr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CMCR_CMD_MODE_CTRL = 8'h32;
    localparam logic [15:0] CMCR_MODE_CTRL_RST = 16'h0030;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CMCR_BIT_HIZ = 15;
    localparam int CMCR_BIT_RESTORE = 14;
    localparam int CMCR_BIT_REMEASURE = 13;
    localparam int CMCR_BIT_REVERSE = 12;
    localparam int CMCR_BIT_ICO = 11;
    localparam int CMCR_BIT_CONS_ASSIST = 6;
    localparam int CMCR_BIT_PIN_SELECT = 5;

    // ------------------------------------------------------------
    // Port carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic stb;
        logic [7:0] cmd;
        logic [15:0] data;
    } cmcr_wr_req_s;

    typedef struct packed {
        logic stb;
        logic [7:0] cmd;
    } cmcr_rd_req_s;

    typedef struct packed {
        logic ack;
        logic [15:0] data;
    } cmcr_rd_rsp_s;

    typedef struct packed {
        logic high_impedance;
        logic regulator_on;
        logic system_from_battery;
        logic converter_halt;
        logic floor_measure_req;
        logic restore_all;
        logic reverse_supply_active;
        logic assist_active;
        logic conservative_assist_active;
        logic input_current_optimizer_on;
    } cmcr_ctrl_s;

    // ------------------------------------------------------------
    // Block state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] mode_ctrl;
        cmcr_rd_rsp_s rsp;
        cmcr_ctrl_s ctrl;
    } cmcr_state_s;

    localparam cmcr_state_s CMCR_STATE_RST = '{
        mode_ctrl: CMCR_MODE_CTRL_RST,
        rsp: '0,
        ctrl: '0
    };

endpackage

//--- tb/cmcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Host model of the register command port
// ----
module cmcr_host (
    // Clock and answer
    input wire logic clk,
    input wire cmcr_pkg::cmcr_rd_rsp_s rsp,
    // Requests
    output var cmcr_pkg::cmcr_wr_req_s wr,
    output var cmcr_pkg::cmcr_rd_req_s rd
);
    import cmcr_pkg::*;
    // Idle with strobes low
    initial begin
        wr = '0;
        rd = '0;
    end
    // One write strobe; released fields are inverted
    task automatic put(input logic [7:0] c, input logic [15:0] v);
        @(negedge clk);
        wr = '{1'b1, c, v};
        @(negedge clk);
        wr = '{1'b0, ~c, ~v};
    endtask
    // One read strobe; the answer is looked for on four falling edges, the first being the one where it drops
    task automatic get(input logic [7:0] c, output logic [15:0] v,
        output logic ok);
        ok = 1'b0;
        v = 16'h0000;
        @(negedge clk);
        rd = '{1'b1, c};
        repeat (4) begin
            @(negedge clk);
            rd = '{1'b0, ~c};
            if (rsp.ack === 1'b1) begin
                ok = 1'b1;
                v = rsp.data;
            end
        end
    endtask
endmodule
`default_nettype wire

//--- tb/charger_mode_control_register_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Bench
// ----
module charger_mode_control_register_tb;
    import cmcr_pkg::*;
    typedef struct packed {
        logic [15:0] v;
        logic pin;
        logic above;
        logic [9:0] ctrl;
    } cmcr_row_s;
    localparam cmcr_row_s ROWS [8] = '{
        '{16'h8000, 1'b0, 1'b1, 10'h380}, '{16'h8000, 1'b0, 1'b0, 10'h200},
        '{16'h1020, 1'b1, 1'b0, 10'h008}, '{16'h1000, 1'b1, 1'b0, 10'h004},
        '{16'h0840, 1'b1, 1'b0, 10'h007}, '{16'h1020, 1'b0, 1'b0, 10'h000},
        '{16'h0800, 1'b0, 1'b0, 10'h001}, '{16'h0060, 1'b1, 1'b0, 10'h000}};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin = 1'b0;
    logic above = 1'b0;
    logic done = 1'b0;
    cmcr_wr_req_s wr;
    cmcr_rd_req_s rd;
    cmcr_rd_rsp_s rsp;
    cmcr_ctrl_s ctrl;
    logic [15:0] d;
    logic ok;
    int errors = 0;
    int n_compared = 0;
    int pulses = 0;
    cmcr_top dut (.CORE_CLK(clk), .RESETN(rst_n), .WR_REQ(wr), .RD_REQ(rd),
        .RD_RSP(rsp), .SHARED_PIN(pin), .INPUT_ABOVE_LOCKOUT(above),
        .FLOOR_MEASURE_DONE(done), .CTRL(ctrl));
    cmcr_host host (.clk(clk), .rsp(rsp), .wr(wr), .rd(rd));
    // 40 MHz clock
    initial begin
        forever #12.5 clk = ~clk;
    end
    // Count restore pulses
    always @(negedge clk) begin
        pulses <= pulses + int'(ctrl.restore_all === 1'b1);
    end
    // Compare and report
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_compared++;
        if (seen !== want) begin
            errors++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, want);
        end
    endtask
    // Verdict
    task automatic tally_and_finish;
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        #100us;
        errors++;
        tally_and_finish();
    end
    // Main sequence
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        host.get(8'h32, d, ok);
        check({15'h0000, ok}, 16'h0001);
        check(d, 16'h0030);
        check({6'h00, ctrl}, 16'h0000);
        foreach (ROWS[i]) begin
            pin = ROWS[i].pin;
            above = ROWS[i].above;
            host.put(8'h32, ROWS[i].v);
            repeat (2) @(negedge clk);
            check(16'(ctrl[9:7]), 16'(ROWS[i].ctrl[9:7]));
            check(16'(ctrl[6:4]), 16'(ROWS[i].ctrl[6:4]));
            check(16'(ctrl[3:2]), 16'(ROWS[i].ctrl[3:2]));
            check(16'(ctrl[1:0]), 16'(ROWS[i].ctrl[1:0]));
            host.get(8'h32, d, ok);
            check(d, ROWS[i].v);
        end
        host.put(8'h32, 16'h4000);
        host.get(8'h32, d, ok);
        check(d, 16'h0030);
        check(16'(pulses), 16'h0001);
        host.put(8'h32, 16'h2000);
        repeat (2) @(negedge clk);
        check({15'h0000, ctrl.converter_halt}, 16'h0001);
        check({15'h0000, ctrl.floor_measure_req}, 16'h0001);
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        repeat (2) @(negedge clk);
        check({15'h0000, ctrl.converter_halt}, 16'h0000);
        host.get(8'h32, d, ok);
        check(d, 16'h0000);
        host.get(8'h33, d, ok);
        check({15'h0000, ok}, 16'h0000);
        host.put(8'h33, 16'hFFFF);
        host.get(8'h32, d, ok);
        check(d, 16'h0000);
        done = 1'b1;
        host.put(8'h32, 16'h2000);
        done = 1'b0;
        @(negedge clk);
        check({15'h0000, ctrl.converter_halt}, 16'h0001);
        host.put(8'h32, 16'h8000);
        rst_n = 1'b0;
        @(negedge clk);
        check({6'h00, ctrl}, 16'h0000);
        rst_n = 1'b1;
        host.get(8'h32, d, ok);
        check(d, 16'h0030);
        tally_and_finish();
    end
endmodule
`default_nettype wire
